// file: shared/rpc_defines.vh
`ifndef RPC_DEFINES_VH
`define RPC_DEFINES_VH

// Release count: internal reset held this many clocks plus one after the synchronised release
`define RPC_RELEASE_CYCLES 16
// Counter width for the release delay
`define RPC_CNT_W 8
// Boot mode encodings
`define RPC_BOOT_NORMAL 1'h0
`define RPC_BOOT_EXTERNAL 1'h1
// Bit position of the reset pull-up control in the pull-up disable register
`define RPC_PUDR_RESET_BIT 0
`define RPC_PUDR_W 8
`define RPC_PUDR_RESET_VAL 8'h00
// Power-on reset stretch in clocks
`define RPC_POR_CYCLES 4
`define RPC_POR_W 3

`endif

// file: rtl/rpc_sync2.v
`timescale 1ns/1ps
`include "rpc_defines.vh"

// Two-flop synchroniser; the first stage is read only by the second
module rpc_sync2 #(
  parameter RESET_VAL = 1'b0
)
(
  input wire clk_sys,
  input wire rst,
  input wire d,
  output wire q
);

  reg s1_q;
  reg s2_q;

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      s1_q <= RESET_VAL;
      s2_q <= RESET_VAL;
    end
    else
    begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end

  assign q = s2_q;

endmodule

// file: rtl/rpc_reset_pin_control.v
`timescale 1ns/1ps
`include "rpc_defines.vh"

// Operation
// - External reset low keeps the chip initialised and held in reset.
// - On external reset release, latch boot strap level as initial mode.
// - Internal reset releases synchronously after a fixed count of clocks.
// - Chip reset alone never resets debug logic; test reset handles that.
// - Power-on reset gives the same chip reset as the external pin, and also resets debug logic.
// - Reset mirror output always shows the internal reset state.
// - Reset pin pull-up on at reset, off when its disable bit is set.
// - Strap high selects off-chip boot unless flash secured; low is normal.
module rpc_reset_pin_control #(
  parameter RELEASE_CYCLES = `RPC_RELEASE_CYCLES,
  parameter CNT_W = `RPC_CNT_W
)
(
  input wire clk_sys,
  input wire rst,
  input wire ext_reset_n,
  input wire test_reset_n,
  input wire boot_source_strap,
  input wire flash_secured,
  input wire pud_wr,
  input wire [`RPC_PUDR_W-1:0] pud_wdata,
  output wire [`RPC_PUDR_W-1:0] pullup_disable_reg,
  output wire reset_pullup_en,
  output wire chip_reset,
  output wire reset_mirror_output,
  output wire debug_reset,
  output wire boot_mode,
  output wire boot_mode_valid
);

  localparam ST_HOLD = 2'h0;
  localparam ST_COUNT = 2'h1;
  localparam ST_RUN = 2'h2;
  // Compare values are cut to the counter widths on purpose
  localparam integer CNT_LAST = RELEASE_CYCLES - 1;
  localparam integer POR_LAST = `RPC_POR_CYCLES;

  wire ext_reset_n_s;
  wire test_reset_n_s;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [CNT_W-1:0] cnt_q;
  reg [CNT_W-1:0] cnt_d;
  reg [`RPC_POR_W-1:0] por_cnt_q;
  reg por_q;
  reg ext_prev_q;
  reg boot_mode_q;
  reg boot_valid_q;
  reg chip_reset_q;
  reg [`RPC_PUDR_W-1:0] pudr_q;
  reg debug_reset_q;
  wire reset_src;
  wire ext_release;

  // Pin may change at any time, so release is only acted on after syncing
  // Starts at the pin's idle high level so rst alone never looks like a release
  rpc_sync2 #(.RESET_VAL(1'b1)) u_sync_ext (
    .clk_sys(clk_sys),
    .rst(rst),
    .d(ext_reset_n),
    .q(ext_reset_n_s)
  );

  rpc_sync2 #(.RESET_VAL(1'b0)) u_sync_trst (
    .clk_sys(clk_sys),
    .rst(rst),
    .d(test_reset_n),
    .q(test_reset_n_s)
  );

  // Power-on reset stretched over a few clocks after rst
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      por_cnt_q <= {`RPC_POR_W{1'b0}};
      por_q <= 1'b1;
    end
    else if (por_cnt_q != POR_LAST[`RPC_POR_W-1:0])
    begin
      por_cnt_q <= por_cnt_q + 1'b1;
      por_q <= 1'b1;
    end
    else
    begin
      por_q <= 1'b0;
    end
  end

  // Power-on and pin feed the same reset path
  assign reset_src = por_q | ~ext_reset_n_s;
  assign ext_release = ext_reset_n_s & ~ext_prev_q;

  always @*
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      ST_HOLD:
      begin
        cnt_d = {CNT_W{1'b0}};
        if (!reset_src)
        begin
          state_d = ST_COUNT;
        end
      end
      ST_COUNT:
      begin
        if (reset_src)
        begin
          state_d = ST_HOLD;
        end
        else if (cnt_q == CNT_LAST[CNT_W-1:0])
        begin
          state_d = ST_RUN;
        end
        else
        begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      ST_RUN:
      begin
        if (reset_src)
        begin
          state_d = ST_HOLD;
        end
      end
      default:
      begin
        state_d = ST_HOLD;
      end
    endcase
  end

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_q <= ST_HOLD;
      cnt_q <= {CNT_W{1'b0}};
      chip_reset_q <= 1'b1;
      ext_prev_q <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      // Registered so the release lands on a clock edge
      chip_reset_q <= (state_d != ST_RUN);
      ext_prev_q <= ext_reset_n_s;
    end
  end

  // Strap sampled once at the pin release; secured flash forces normal boot
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      boot_mode_q <= `RPC_BOOT_NORMAL;
      boot_valid_q <= 1'b0;
    end
    else if (ext_release)
    begin
      boot_mode_q <= (boot_source_strap & ~flash_secured) ?
                     `RPC_BOOT_EXTERNAL : `RPC_BOOT_NORMAL;
      boot_valid_q <= 1'b1;
    end
    else if (!ext_reset_n_s)
    begin
      // Dropped while the pin is low so a stale mode is never reported
      boot_valid_q <= 1'b0;
    end
  end

  // Pull-up disable register cleared by rst and while the power-on or pin reset source is active
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      pudr_q <= `RPC_PUDR_RESET_VAL;
    end
    else if (reset_src)
    begin
      pudr_q <= `RPC_PUDR_RESET_VAL;
    end
    else if (pud_wr)
    begin
      pudr_q <= pud_wdata;
    end
  end

  // Debug logic sees test reset and power-on only, never the chip reset pin;
  // registered so its reset net cannot glitch when both sources move at once
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      debug_reset_q <= 1'b1;
    end
    else
    begin
      debug_reset_q <= ~test_reset_n_s | por_q;
    end
  end

  assign pullup_disable_reg = pudr_q;
  assign reset_pullup_en = ~pudr_q[`RPC_PUDR_RESET_BIT];
  assign chip_reset = chip_reset_q;
  assign reset_mirror_output = chip_reset_q;
  assign debug_reset = debug_reset_q;
  assign boot_mode = boot_mode_q;
  assign boot_mode_valid = boot_valid_q;

endmodule

// file: test/rpc_sva.sv
`timescale 1ns/1ps
module rpc_sva (
  input wire clk_sys,
  input wire rst,
  input wire ext_reset_n,
  input wire test_reset_n,
  input wire boot_source_strap,
  input wire flash_secured,
  input wire [7:0] pullup_disable_reg,
  input wire reset_pullup_en,
  input wire chip_reset,
  input wire reset_mirror_output,
  input wire debug_reset,
  input wire boot_mode,
  input wire boot_mode_valid
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  chk_mirror_same: assert property (reset_mirror_output == chip_reset) else $error("mir");
  chk_por_holds: assert property ($fell(rst) |-> chip_reset [*8]) else $error("por");
  chk_pin_holds: assert property (!ext_reset_n [*3] |=> chip_reset) else $error("hold");
  chk_pullup_inv: assert property (reset_pullup_en != pullup_disable_reg[0]) else $error("pu");
  chk_dbg_kept: assert property (test_reset_n [*8] |=> !debug_reset) else $error("dbg");
  chk_dbg_full: assert property (!test_reset_n [*3] |=> debug_reset) else $error("tst");
  chk_boot_hold: assert property ($changed(boot_mode) |-> $rose(boot_mode_valid))
    else $error("bm");
  chk_boot_sel: assert property ($rose(boot_mode_valid) |->
    boot_mode == (boot_source_strap && !flash_secured)) else $error("sel");
  chk_release_cnt: assert property ($rose(boot_mode_valid) |-> chip_reset [*8])
    else $error("rel");
endmodule
bind rpc_reset_pin_control rpc_sva u_sva (.*);

// file: test/rpc_board.sv
`timescale 1ns/1ps
module rpc_board (
  input wire clk_sys,
  output logic ext_reset_n = 1'h1,
  output logic test_reset_n = 1'h1,
  output logic boot_source_strap = 1'h1
);
  // Chip-only reset leaves the test pin high so debug logic survives
  task hit(input bit full, input bit s, input int k);
    @(posedge clk_sys);
    #1;
    boot_source_strap = s;
    ext_reset_n = 1'h0;
    test_reset_n = !full;
    repeat (k) @(posedge clk_sys);
    #1;
    ext_reset_n = 1'h1;
    test_reset_n = 1'h1;
  endtask
endmodule

// file: test/tb_reset_pin_control.sv
`timescale 1ns/1ps
module tb_reset_pin_control;
  logic clk_sys = 0, rst = 1, flash_secured = 0, pud_wr = 0;
  logic [7:0] pud_wdata = 8'h01;
  wire ext_reset_n, test_reset_n, boot_source_strap, chip_reset, reset_mirror_output;
  wire [7:0] pullup_disable_reg;
  wire reset_pullup_en, debug_reset, boot_mode, boot_mode_valid;
  int mismatches = 0, num_checks = 0, n;
  rpc_board u_brd (.*);
  rpc_reset_pin_control u_dut (.*);
  initial forever #4 clk_sys = ~clk_sys;
  task chk(input bit c);
    num_checks++;
    if (!c)
    begin
      mismatches++;
      $display("BAD %0t check %0d", $time, num_checks);
    end
  endtask
  task step;
    @(posedge clk_sys);
    #1;
  endtask
  // Bounded wait, so a stuck reset ends in a count mismatch
  task wrel;
    n = 0;
    while (chip_reset !== 1'b0 && n < 40)
    begin
      step;
      n++;
    end
  endtask
  task rel(input bit s, input bit sec, input bit e);
    flash_secured = sec;
    u_brd.hit(0, s, 4);
    chk(chip_reset === 1'b1 && debug_reset === 1'b0);
    wrel;
    chk(n >= 17 && n <= 21);
    chk(boot_mode === e && boot_mode_valid === 1'b1);
    $display("boot done");
  endtask
  task pud;
    pud_wr = 1;
    step;
    pud_wr = 0;
    step;
    chk(reset_pullup_en === 1'b0);
    u_brd.hit(1, 0, 4);
    chk(pullup_disable_reg === 8'h00 && reset_pullup_en && debug_reset === 1'b1);
    wrel;
    $display("pud done");
  endtask
  // Power-on stretch, then the release count; boot mode is not captured here
  task power_up;
    repeat (16) step;
    chk(chip_reset === 1'b1 && reset_mirror_output === 1'b1);
    rst = 0;
    wrel;
    chk(n >= 21 && n <= 23);
    chk(boot_mode === 1'b0 && boot_mode_valid === 1'b0);
    chk(reset_pullup_en === 1'b1 && debug_reset === 1'b0);
    $display("power-up done");
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (2000) @(posedge clk_sys);
    mismatches++;
    end_of_test;
  end
  initial
  begin
    power_up;
    pud;
    rel(1, 0, 1);
    rel(0, 0, 0);
    rel(1, 1, 0);
    end_of_test;
  end
endmodule
